// [umls_regs.svh]
// register offsets, field positions and reset values of the modem/line status block
// assumes inclusion by bare name from the design and test files
`ifndef UMLS_REGS_SVH
`define UMLS_REGS_SVH
`define UMLS_ADDR_MCR     3'h4
`define UMLS_ADDR_LSR     3'h5
`define UMLS_ADDR_MSR     3'h6
`define UMLS_ADDR_LVL     3'h7
`define UMLS_MCR_RST      8'h00
`define UMLS_BANK_RST     8'h00
`define UMLS_B_CLKSEL     7
`define UMLS_B_IREN       6
`define UMLS_B_LOOP       4
`define UMLS_B_INTEN      3
`define UMLS_B_AUX1       2
`define UMLS_B_RTS        1
`define UMLS_B_DTR        0
`define UMLS_B_LVLEN      0
`define UMLS_BANK_GEN     2'b00
`define UMLS_BANK_X1      2'b01
`define UMLS_BANK_X2      2'b10
`define UMLS_DIV4_LAST    2'h3
`define UMLS_ZERO8        8'h00
`define UMLS_BANK_HI      2
`define UMLS_BANK_LO      1
`define UMLS_LSR_ERR      7
`define UMLS_LSR_TEMT     6
`define UMLS_LSR_BRK      4
`define UMLS_LSR_FRM      3
`define UMLS_LSR_PAR      2
`define UMLS_LSR_RDY      0
`define UMLS_MSR_HI       7
`define UMLS_MSR_LO       4
`endif

// [umls_pkg.sv]
// shared types of the modem/line status block
// assumes umls_regs.svh on the include path
package umls_pkg;
  typedef enum logic [1:0] {BANK_GEN, BANK_X1, BANK_X2, BANK_RSV} umls_bank_e;
  typedef logic [3:0] umls_modem_t;
endpackage : umls_pkg

// [umls_sync_if.sv]
// carries the raw modem inputs into the synchroniser and the clean copies back
// assumes one clock shared with the top module
`timescale 1ns/100ps
interface umls_sync_if;
  umls_pkg::umls_modem_t rawLvl;
  umls_pkg::umls_modem_t syncLvl;
  modport src (output rawLvl, input syncLvl);
  modport snk (input rawLvl, output syncLvl);
endinterface : umls_sync_if

// [umls_sync.sv]
// two-stage synchroniser for the four modem input pins
// assumes inputs asynchronous to clk
`timescale 1ns/100ps
module umls_sync (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // pin levels
  umls_sync_if.snk sif
);
  typedef struct packed {
    umls_pkg::umls_modem_t meta;
    umls_pkg::umls_modem_t sync;
  } umls_sync_s;
  umls_sync_s st_r;
  umls_sync_s st_nxt;
  always_comb begin
    st_nxt      = st_r;
    st_nxt.meta = sif.rawLvl;
    st_nxt.sync = st_r.meta;
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= '{meta: 4'hF, sync: 4'hF};
    end else begin
      st_r <= st_nxt;
    end
  end
  assign sif.syncLvl = st_r.sync;
endmodule : umls_sync

// [umls_modem_line_status.sv]
// modem control, line status, modem status and bank select of one uart channel
// assumes a byte register port with read data one cycle after the read strobe
// Functional notes
// - clock select picks divide-by-1 or divide-by-4
// - infrared enable routes data through encoder, idle low
// - loopback disconnects pins except aux two and irq, wires outputs back inside
// - loopback modem interrupts sourced from low control bits
// - interrupt gate: off tristates irq, aux two high
// - aux one bit drives no pin, loopback ring
// - rts and dtr outputs are inverted control bits
// - fifo error flag while any entry errored
// - transmitter empty when holding and shift empty
// - holding empty sets on transfer, clears on write
// - break flag on frame-long low, one entry
// - framing error reflects top of fifo
// - parity error reflects top of fifo
// - overrun when fifo full, fifo kept intact
// - data ready while any character held
// - status upper bits are complemented inputs or loopback
// - cd dsr cts change on either edge
// - ring change only on low-to-high transition
// - status read clears all change flags
// - modem interrupt while any change flag set
// - status and bank select share one address
// - bank field selects general, extra one, extra two
// - level counters readable only with bank zero
`timescale 1ns/100ps
`include "umls_regs.svh"
module umls_modem_line_status (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // register port
  input  wire logic [2:0] regAddr,
  input  wire logic [7:0] regWdata,
  input  wire logic       regWr,
  input  wire logic       regRd,
  output logic      [7:0] regRdata,
  // serial core status
  input  wire logic       rxFifoErr,
  input  wire logic       txHoldEmpty,
  input  wire logic       txShiftEmpty,
  input  wire logic       txHoldWrite,
  input  wire logic       txMoveToShift,
  input  wire logic       rxBreakSeen,
  input  wire logic       rxFrameErrTop,
  input  wire logic       rxParityErrTop,
  input  wire logic       rxCharDone,
  input  wire logic       rxFifoFull,
  input  wire logic       rxDataHeld,
  input  wire logic       rxLsrRead,
  input  wire logic [7:0] txSpaceCount,
  input  wire logic [7:0] rxFillCount,
  input  wire logic       coreTx,
  input  wire logic       irTxEnc,
  input  wire logic       coreIrq,
  // modem and serial pins, active low except irqOut and irqOe
  input  wire logic       rxPinN,
  input  wire logic       ctsN,
  input  wire logic       dsrN,
  input  wire logic       cdN,
  input  wire logic       riN,
  output logic            txPinN,
  output logic            rtsN,
  output logic            dtrN,
  output logic            auxOutTwoN,
  output logic            irqOut,
  output logic            irqOe,
  // to core
  output logic            baudClkEn,
  output logic            rxToCore,
  output logic            irMode,
  output logic            modemIrq,
  output logic [1:0]      bankSel,
  output logic            overrunDrop
);
  typedef struct packed {
    logic [7:0]  modem_control;
    logic [7:0]  bank;
    logic [3:0]  delta;
    logic [3:0]  prevLvl;
    logic        overrun;
    logic        holdEmpty;
    logic [1:0]  divCnt;
    logic [7:0]  rdata;
    logic        txPin;
    logic        rts;
    logic        dtr;
    logic        aux2;
    logic        irq;
    logic        irqEn;
    logic        baudEn;
    logic        rxIn;
    logic        mIrq;
    logic        drop;
    logic [1:0]  rxSync;
  } umls_state_s;
  umls_state_s st_r;
  umls_state_s st_nxt;
  logic        rstn;
  logic [1:0]  rstSync_r;
  logic        loop;
  logic [3:0]  lvl;
  logic [7:0]  line_status;
  logic [7:0]  modem_input_status;
  logic        hit;
  umls_sync_if sif ();
  assign rstn = rstSync_r[1];
  assign loop = st_r.modem_control[`UMLS_B_LOOP];
  assign sif.rawLvl = {cdN, riN, dsrN, ctsN};
  umls_sync u_sync (
    .clk  (clk),
    .rstn (rstn),
    .sif  (sif.snk)
  );
  always_comb begin
    // asserted levels: cd, ri, dsr, cts
    if (loop) begin
      lvl = {st_r.modem_control[`UMLS_B_INTEN], st_r.modem_control[`UMLS_B_AUX1],
             st_r.modem_control[`UMLS_B_DTR], st_r.modem_control[`UMLS_B_RTS]};
    end else begin
      lvl = ~sif.syncLvl;
    end
    line_status = {rxFifoErr,
           txHoldEmpty & txShiftEmpty,
           st_r.holdEmpty,
           rxBreakSeen,
           rxFrameErrTop,
           rxParityErrTop,
           st_r.overrun,
           rxDataHeld};
    modem_input_status = {lvl, st_r.delta};
    hit = regRd && (regAddr == `UMLS_ADDR_MSR);
  end
  always_comb begin
    st_nxt = st_r;
    st_nxt.rxSync  = {st_r.rxSync[0], rxPinN};
    if (regWr && regAddr == `UMLS_ADDR_MCR) begin
      st_nxt.modem_control = regWdata;
    end else if (regWr && regAddr == `UMLS_ADDR_MSR) begin
      st_nxt.bank = regWdata;
    end
    // change flags: set wins over read clear
    st_nxt.prevLvl = lvl;
    st_nxt.delta = hit ? 4'h0 : st_r.delta;
    st_nxt.delta[3] = st_nxt.delta[3] | (lvl[3] ^ st_r.prevLvl[3]);
    st_nxt.delta[2] = st_nxt.delta[2] | (~lvl[2] & st_r.prevLvl[2]);
    st_nxt.delta[1] = st_nxt.delta[1] | (lvl[1] ^ st_r.prevLvl[1]);
    st_nxt.delta[0] = st_nxt.delta[0] | (lvl[0] ^ st_r.prevLvl[0]);
    st_nxt.mIrq = |st_nxt.delta;
    if (rxCharDone && rxFifoFull) begin
      st_nxt.overrun = 1'b1;
    end else if (rxLsrRead) begin
      st_nxt.overrun = 1'b0;
    end
    st_nxt.drop = rxCharDone && rxFifoFull;
    if (txMoveToShift) begin
      st_nxt.holdEmpty = 1'b1;
    end else if (txHoldWrite) begin
      st_nxt.holdEmpty = 1'b0;
    end
    st_nxt.divCnt = st_r.divCnt + 2'h1;
    st_nxt.baudEn = st_r.modem_control[`UMLS_B_CLKSEL] ? (st_r.divCnt == `UMLS_DIV4_LAST) : 1'b1;
    // loopback keeps pins idle and feeds tx back to rx
    if (loop) begin
      st_nxt.txPin = 1'b1;
      st_nxt.rxIn  = coreTx;
      st_nxt.rts   = 1'b1;
      st_nxt.dtr   = 1'b1;
    end else begin
      st_nxt.txPin = st_r.modem_control[`UMLS_B_IREN] ? irTxEnc : coreTx;
      st_nxt.rxIn  = st_r.rxSync[1];
      st_nxt.rts   = ~st_r.modem_control[`UMLS_B_RTS];
      st_nxt.dtr   = ~st_r.modem_control[`UMLS_B_DTR];
    end
    st_nxt.aux2  = ~st_r.modem_control[`UMLS_B_INTEN];
    st_nxt.irqEn = st_r.modem_control[`UMLS_B_INTEN];
    st_nxt.irq   = coreIrq;
    st_nxt.rdata = `UMLS_ZERO8;
    if (regRd) begin
      if (regAddr == `UMLS_ADDR_MCR) begin
        st_nxt.rdata = st_r.modem_control;
      end else if (regAddr == `UMLS_ADDR_LSR) begin
        st_nxt.rdata = line_status;
      end else if (regAddr == `UMLS_ADDR_MSR) begin
        st_nxt.rdata = modem_input_status;
      end else if (regAddr == `UMLS_ADDR_LVL) begin
        if (st_r.bank[`UMLS_BANK_HI:`UMLS_BANK_LO] == `UMLS_BANK_GEN &&
            st_r.bank[`UMLS_B_LVLEN]) begin
          st_nxt.rdata = st_r.modem_control[`UMLS_B_LOOP] ? rxFillCount : txSpaceCount;
        end
      end
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rstSync_r <= 2'b00;
    end else begin
      rstSync_r <= {rstSync_r[0], 1'b1};
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r         <= '0;
      st_r.modem_control     <= `UMLS_MCR_RST;
      st_r.bank    <= `UMLS_BANK_RST;
      st_r.txPin   <= 1'b1;
      st_r.rts     <= 1'b1;
      st_r.dtr     <= 1'b1;
      st_r.aux2    <= 1'b1;
      st_r.rxIn    <= 1'b1;
      st_r.rxSync  <= 2'b11;
      st_r.holdEmpty <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign regRdata    = st_r.rdata;
  assign txPinN      = st_r.txPin;
  assign rtsN        = st_r.rts;
  assign dtrN        = st_r.dtr;
  assign auxOutTwoN  = st_r.aux2;
  assign irqOut      = st_r.irq;
  assign irqOe       = st_r.irqEn;
  assign baudClkEn   = st_r.baudEn;
  assign rxToCore    = st_r.rxIn;
  assign irMode      = st_r.modem_control[`UMLS_B_IREN];
  assign modemIrq    = st_r.mIrq;
  assign bankSel     = st_r.bank[`UMLS_BANK_HI:`UMLS_BANK_LO];
  assign overrunDrop = st_r.drop;

  property p_rts;
    @(posedge clk) disable iff (!rstn)
      !loop |=> (rtsN == !$past(st_r.modem_control[`UMLS_B_RTS]));
  endproperty
  a_rts: assert property (p_rts) else $error("rts mismatch");
  property p_int;
    @(posedge clk) disable iff (!rstn) 1'b1 |=> (irqOe == !auxOutTwoN);
  endproperty
  a_int: assert property (p_int) else $error("irq gate mismatch");
  property p_clr;
    @(posedge clk) disable iff (!rstn) (lvl == $past(lvl)) && hit |=> st_r.delta == 4'h0;
  endproperty
  a_clr: assert property (p_clr) else $error("read did not clear");
  property p_ri;
    @(posedge clk) disable iff (!rstn) (lvl[2] ##1 !lvl[2]) |=> st_r.delta[2];
  endproperty
  a_ri: assert property (p_ri) else $error("ring rise missed");
  property p_cts;
    @(posedge clk) disable iff (!rstn) (lvl[0] != $past(lvl[0])) |=> st_r.delta[0];
  endproperty
  a_cts: assert property (p_cts) else $error("cts change missed");
  property p_mirq;
    @(posedge clk) disable iff (!rstn) (|st_r.delta) |-> modemIrq;
  endproperty
  a_mirq: assert property (p_mirq) else $error("modem irq missing");
  property p_ovr;
    @(posedge clk) disable iff (!rstn) (rxCharDone && rxFifoFull) |=> st_r.overrun && overrunDrop;
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun not flagged");
  property p_loop;
    @(posedge clk) disable iff (!rstn) $past(loop) && loop |-> txPinN && rtsN && dtrN;
  endproperty
  a_loop: assert property (p_loop) else $error("pins not idle in loopback");
  property p_div;
    @(posedge clk) disable iff (!rstn)
      st_r.modem_control[`UMLS_B_CLKSEL] && $past(st_r.modem_control[`UMLS_B_CLKSEL]) && baudClkEn |=> !baudClkEn;
  endproperty
  a_div: assert property (p_div) else $error("divider wrong");
  property p_clk1;
    @(posedge clk) disable iff (!rstn)
      !st_r.modem_control[`UMLS_B_CLKSEL] |=> baudClkEn;
  endproperty
  a_clk1: assert property (p_clk1) else $error("undivided baud enable missing");
  property p_irtx;
    @(posedge clk) disable iff (!rstn)
      !loop && st_r.modem_control[`UMLS_B_IREN] |=> txPinN == $past(irTxEnc);
  endproperty
  a_irtx: assert property (p_irtx) else $error("infrared tx not routed");
  property p_lbrx;
    @(posedge clk) disable iff (!rstn)
      loop |=> rxToCore == $past(coreTx);
  endproperty
  a_lbrx: assert property (p_lbrx) else $error("loopback rx not fed from tx");
  property p_lbint;
    @(posedge clk) disable iff (!rstn)
      loop && $past(loop) &&
      (st_r.modem_control[`UMLS_B_RTS] != $past(st_r.modem_control[`UMLS_B_RTS])) |=> st_r.delta[0];
  endproperty
  a_lbint: assert property (p_lbint) else $error("loopback change not flagged");
  property p_lbmsr;
    @(posedge clk) disable iff (!rstn)
      loop && hit |=> regRdata[`UMLS_MSR_HI:`UMLS_MSR_LO] ==
      {$past(st_r.modem_control[`UMLS_B_INTEN]), $past(st_r.modem_control[`UMLS_B_AUX1]),
       $past(st_r.modem_control[`UMLS_B_DTR]), $past(st_r.modem_control[`UMLS_B_RTS])};
  endproperty
  a_lbmsr: assert property (p_lbmsr) else $error("loopback status wrong");
  property p_aux;
    @(posedge clk) disable iff (!rstn)
      st_r.modem_control[`UMLS_B_INTEN] |=> !auxOutTwoN && irqOe;
  endproperty
  a_aux: assert property (p_aux) else $error("aux two not low with gate on");
  property p_dtr;
    @(posedge clk) disable iff (!rstn)
      !loop |=> (dtrN == !$past(st_r.modem_control[`UMLS_B_DTR]));
  endproperty
  a_dtr: assert property (p_dtr) else $error("dtr mismatch");
  property p_ovrclr;
    @(posedge clk) disable iff (!rstn)
      rxLsrRead && !(rxCharDone && rxFifoFull) |=> !st_r.overrun;
  endproperty
  a_ovrclr: assert property (p_ovrclr) else $error("overrun not cleared");
  property p_temt;
    @(posedge clk) disable iff (!rstn)
      regRd && regAddr == `UMLS_ADDR_LSR |=>
      regRdata[`UMLS_LSR_TEMT] == ($past(txHoldEmpty) && $past(txShiftEmpty));
  endproperty
  a_temt: assert property (p_temt) else $error("transmitter empty wrong");
  property p_rdy;
    @(posedge clk) disable iff (!rstn)
      regRd && regAddr == `UMLS_ADDR_LSR |=> regRdata[`UMLS_LSR_RDY] == $past(rxDataHeld);
  endproperty
  a_rdy: assert property (p_rdy) else $error("data ready wrong");
  property p_lsre;
    @(posedge clk) disable iff (!rstn)
      regRd && regAddr == `UMLS_ADDR_LSR |=> regRdata[`UMLS_LSR_ERR] == $past(rxFifoErr) &&
      regRdata[`UMLS_LSR_BRK] == $past(rxBreakSeen) &&
      regRdata[`UMLS_LSR_FRM] == $past(rxFrameErrTop) &&
      regRdata[`UMLS_LSR_PAR] == $past(rxParityErrTop);
  endproperty
  a_lsre: assert property (p_lsre) else $error("receive error flags wrong");
  property p_bank;
    @(posedge clk) disable iff (!rstn)
      regWr && regAddr == `UMLS_ADDR_MSR |=>
      bankSel == $past(regWdata[`UMLS_BANK_HI:`UMLS_BANK_LO]);
  endproperty
  a_bank: assert property (p_bank) else $error("bank select not written");
  property p_lvl;
    @(posedge clk) disable iff (!rstn)
      regRd && regAddr == `UMLS_ADDR_LVL &&
      st_r.bank[`UMLS_BANK_HI:`UMLS_BANK_LO] != `UMLS_BANK_GEN |=> regRdata == `UMLS_ZERO8;
  endproperty
  a_lvl: assert property (p_lvl) else $error("level counter readable in extra bank");
  property p_rinf;
    @(posedge clk) disable iff (!rstn)
      !hit && lvl[2] && !$past(lvl[2]) |=> st_r.delta[2] == $past(st_r.delta[2]);
  endproperty
  a_rinf: assert property (p_rinf) else $error("ring change on wrong edge");
  c_loop: cover property (@(posedge clk) disable iff (!rstn) loop && modemIrq);
  c_rd: cover property (@(posedge clk) disable iff (!rstn) hit && |st_r.delta);
  c_ovr: cover property (@(posedge clk) disable iff (!rstn) overrunDrop);
  c_ri: cover property (@(posedge clk) disable iff (!rstn) st_r.delta[2]);
endmodule : umls_modem_line_status

// [umls_modem_model.sv]
// modem-side partner driving the active-low modem and serial pins
// assumes the bench sets wanted levels; pins settle off the clock edge
`timescale 1ns/100ps
module umls_modem_model (
  // wanted levels {cd, ri, dsr, cts} and serial line
  input  wire logic [3:0] want,
  input  wire logic       rxLvl,
  // pins
  output logic            cdN,
  output logic            riN,
  output logic            dsrN,
  output logic            ctsN,
  output logic            rxPinN
);
  // skew keeps pin moves away from the sampling edge
  assign #7 {cdN, riN, dsrN, ctsN} = want;
  assign #7 rxPinN = rxLvl;
endmodule : umls_modem_model

// [uart_modem_line_status_test.sv]
// self-checking bench of the modem/line status block
// assumes read data stand in the cycle after the read strobe
`timescale 1ns/100ps
`include "umls_regs.svh"
module uart_modem_line_status_test;
  logic        clk, resetn, regWr, regRd, pend, coreTx, irTxEnc, coreIrq, rxLvl;
  logic        rxFifoErr, txHoldEmpty, txShiftEmpty, txHoldWrite, txMoveToShift, rxBreakSeen;
  logic        rxFrameErrTop, rxParityErrTop, rxCharDone, rxFifoFull, rxDataHeld, rxLsrRead;
  logic        rxPinN, ctsN, dsrN, cdN, riN, txPinN, rtsN, dtrN, auxOutTwoN, irqOut, irqOe;
  logic        baudClkEn, rxToCore, irMode, modemIrq, overrunDrop;
  logic [1:0]  bankSel;
  logic [2:0]  regAddr;
  logic [3:0]  want, nw, flag;
  logic [7:0]  regWdata, regRdata, txSpaceCount, rxFillCount;
  logic [15:0] q;
  logic [15:0] expQ[$];
  int          n_errors, cmp_count, k, bauds;

  umls_modem_line_status DUT (.clk, .resetn, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
    .rxFifoErr, .txHoldEmpty, .txShiftEmpty, .txHoldWrite, .txMoveToShift, .rxBreakSeen,
    .rxFrameErrTop, .rxParityErrTop, .rxCharDone, .rxFifoFull, .rxDataHeld, .rxLsrRead,
    .txSpaceCount, .rxFillCount, .coreTx, .irTxEnc, .coreIrq, .rxPinN, .ctsN, .dsrN, .cdN,
    .riN, .txPinN, .rtsN, .dtrN, .auxOutTwoN, .irqOut, .irqOe, .baudClkEn, .rxToCore,
    .irMode, .modemIrq, .bankSel, .overrunDrop);
  umls_modem_model PEER (.want, .rxLvl, .cdN, .riN, .dsrN, .ctsN, .rxPinN);

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wr

  // expectation queued with a mask of the bits that matter
  task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    expQ.push_back({e, m});
    @(posedge clk);
    regRd <= 1'b0;
  endtask : rd

  task automatic pul(input int w);
    @(posedge clk);
    case (w)
      0: txHoldWrite <= 1'b1;
      1: txMoveToShift <= 1'b1;
      2: rxCharDone <= 1'b1;
      default: rxLsrRead <= 1'b1;
    endcase
    @(posedge clk);
    {txHoldWrite, txMoveToShift, rxCharDone, rxLsrRead} <= 4'h0;
  endtask : pul

  always @(posedge clk) pend <= regRd;
  always @(negedge clk) begin
    if (pend) begin
      q = expQ.pop_front();
      chk("regRdata", regRdata & q[7:0], q[15:8]);
    end
  end

  initial begin
    #(5000 * 40);
    n_errors++;
    summarize();
  end

  initial begin
    void'($urandom(32'hadb8));
    {regWr, regRd, txHoldWrite, txMoveToShift, rxCharDone, rxLsrRead} = '0;
    {regAddr, regWdata, txSpaceCount, rxFillCount, coreTx, irTxEnc, coreIrq} = '0;
    {rxFifoErr, txHoldEmpty, txShiftEmpty, rxBreakSeen, rxFrameErrTop, rxParityErrTop} = '0;
    {rxFifoFull, rxDataHeld} = '0;
    want = 4'hF;
    rxLvl = 1'b1;
    resetn = 1'b0;
    cyc(20);
    resetn <= 1'b1;
    cyc(3);
    @(negedge clk);
    chk("pins", {rtsN, dtrN, auxOutTwoN, irqOe}, 8'h0E);
    rd(`UMLS_ADDR_MCR, `UMLS_MCR_RST, 8'hFF);
    coreIrq <= 1'b1;
    wr(`UMLS_ADDR_MCR, 8'h0B);
    cyc(3);
    @(negedge clk);
    chk("pins", {rtsN, dtrN, auxOutTwoN, irqOe, irqOut}, 8'h03);
    rd(`UMLS_ADDR_MCR, 8'h0B, 8'hDF);
    for (k = 0; k < 2; k++) begin
      wr(`UMLS_ADDR_MCR, {k[0], 7'h0B});
      cyc(4);
      bauds = 0;
      repeat (40) begin
        @(negedge clk);
        bauds += baudClkEn;
      end
      chk("baudClkEn", 8'(bauds), k ? 8'h0A : 8'h28);
    end
    @(posedge clk);
    coreTx <= 1'b1;
    rxLvl <= 1'b0;
    wr(`UMLS_ADDR_MCR, 8'h40);
    cyc(3);
    @(negedge clk);
    chk("irMode", irMode, 8'h01);
    chk("txPinN", txPinN, 8'h00);
    chk("rxToCore", rxToCore, 8'h00);
    for (k = 0; k < 8; k++) begin
      @(posedge clk);
      {rxFifoErr, txHoldEmpty, txShiftEmpty, rxBreakSeen, rxFrameErrTop, rxParityErrTop,
       rxDataHeld} <= 7'($urandom);
      cyc(2);
      rd(`UMLS_ADDR_LSR, {rxFifoErr, txHoldEmpty & txShiftEmpty, 1'b0, rxBreakSeen,
         rxFrameErrTop, rxParityErrTop, 1'b0, rxDataHeld}, 8'hDD);
    end
    pul(0);
    rd(`UMLS_ADDR_LSR, 8'h00, 8'h20);
    pul(1);
    rd(`UMLS_ADDR_LSR, 8'h20, 8'h20);
    pul(2);
    rd(`UMLS_ADDR_LSR, 8'h00, 8'h02);
    rxFifoFull <= 1'b1;
    pul(2);
    @(negedge clk);
    chk("overrunDrop", overrunDrop, 8'h01);
    rd(`UMLS_ADDR_LSR, 8'h02, 8'h02);
    pul(3);
    rd(`UMLS_ADDR_LSR, 8'h00, 8'h02);
    wr(`UMLS_ADDR_MCR, 8'h08);
    rd(`UMLS_ADDR_MSR, 8'h00, 8'h00);
    @(negedge clk);
    chk("txPinN", txPinN, 8'h01);
    for (k = 0; k < 8; k++) begin
      nw = want ^ (4'h1 << k[1:0]);
      flag = (k == 2) ? 4'h0 : (4'h1 << k[1:0]);
      @(posedge clk);
      want <= nw;
      cyc(6);
      @(negedge clk);
      chk("modemIrq", modemIrq, {7'h0, k != 2});
      rd(`UMLS_ADDR_MSR, {~nw, flag}, 8'hFF);
      rd(`UMLS_ADDR_MSR, {~nw, 4'h0}, 8'hFF);
    end
    wr(`UMLS_ADDR_MCR, 8'h1D);
    cyc(3);
    @(negedge clk);
    chk("pins", {rtsN, dtrN}, 8'h03);
    rd(`UMLS_ADDR_MSR, 8'hE0, 8'hF0);
    want <= 4'h0;
    coreTx <= 1'b0;
    wr(`UMLS_ADDR_MCR, 8'h1F);
    cyc(6);
    @(negedge clk);
    chk("modemIrq", modemIrq, 8'h01);
    chk("rxToCore", rxToCore, 8'h00);
    rd(`UMLS_ADDR_MSR, 8'hF1, 8'hFF);
    wr(`UMLS_ADDR_MCR, 8'h00);
    for (k = 0; k < 3; k++) begin
      wr(`UMLS_ADDR_MSR, {5'h0, k[1:0], 1'b0});
      cyc(2);
      @(negedge clk);
      chk("bankSel", bankSel, 8'(k));
    end
    rd(`UMLS_ADDR_MCR, 8'h00, 8'hFF);
    @(posedge clk);
    txSpaceCount <= 8'($urandom);
    rxFillCount <= 8'($urandom);
    wr(`UMLS_ADDR_MSR, 8'h01);
    rd(`UMLS_ADDR_LVL, txSpaceCount, 8'hFF);
    wr(`UMLS_ADDR_MCR, 8'h10);
    rd(`UMLS_ADDR_LVL, rxFillCount, 8'hFF);
    wr(`UMLS_ADDR_MSR, 8'h03);
    rd(`UMLS_ADDR_LVL, 8'h00, 8'hFF);
    rd(3'h0, 8'h00, 8'hFF);
    cyc(4);
    summarize();
  end
endmodule : uart_modem_line_status_test
